// ==== design/bpet_pkg.sv ====
// Package: register map, control fields and states of the pixel-source stage
package bpet_pkg;

    // Register indices; the byte address on APB is four times the index
    localparam logic [7:0] BPET_IDX_CTRL0 = 8'h00;
    localparam logic [7:0] BPET_IDX_CTRL1 = 8'h01;
    localparam logic [7:0] BPET_IDX_SRC = 8'h02;
    localparam logic [7:0] BPET_IDX_DIMX = 8'h06;
    localparam logic [7:0] BPET_IDX_DIMY = 8'h07;
    localparam logic [7:0] BPET_IDX_ROP = 8'h09;
    localparam logic [7:0] BPET_IDX_FG = 8'h0a;
    localparam logic [7:0] BPET_IDX_BG = 8'h0b;
    localparam logic [7:0] BPET_IDX_TCOL = 8'h0c;
    localparam logic [7:0] BPET_IDX_TMASK = 8'h0d;
    localparam logic [7:0] BPET_IDX_PMASK = 8'h0e;
    localparam logic [7:0] BPET_IDX_HOST = 8'h0f;
    localparam logic [7:0] BPET_IDX_STAT = 8'h10;
    localparam logic [7:0] BPET_IDX_DST = 8'h11;

    // Control register 0 fields
    localparam int BPET_C0_FMT_LSB = 0;
    localparam int BPET_C0_PACKED = 2;
    localparam int BPET_C0_EXTRACT = 3;
    localparam int BPET_C0_PATTERN = 4;
    localparam int BPET_C0_START = 5;
    localparam int BPET_C0_EXPAND = 6;
    // Control register 1 fields
    localparam int BPET_C1_MONO_TR = 0;
    localparam int BPET_C1_TR_EN = 1;
    localparam int BPET_C1_TR_POL = 2;

    // Source formats
    localparam logic [1:0] BPET_FMT_COLOR = 2'h0;
    localparam logic [1:0] BPET_FMT_FIXED = 2'h1;
    localparam logic [1:0] BPET_FMT_HOST = 2'h2;

    // Reset values
    localparam logic [15:0] BPET_RST_ZERO = 16'h0000;
    localparam logic [7:0] BPET_RST_PMASK = 8'hff;
    localparam logic [3:0] BPET_RST_ROP = 4'h3;

    // Pattern geometry: 8 by 8 pixels in a 64-pixel aligned block
    localparam int BPET_PAT_BITS = 3;
    localparam logic [15:0] BPET_PAT_ALIGN = 16'hffc0;
    localparam logic [2:0] BPET_HOST_PIX = 3'h4;

    typedef struct packed {
        logic [1:0] fmt;
        logic packed_mode;
        logic extract;
        logic pattern;
        logic expand;
        logic mono_tr;
        logic tr_en;
        logic tr_pol;
    } bpet_cfg_s;

    typedef struct packed {
        logic [7:0] fg;
        logic [7:0] bg;
        logic [7:0] tcol;
        logic [7:0] tmask;
        logic [7:0] pmask;
        logic [3:0] rop;
    } bpet_colors_s;

    typedef enum logic [3:0] {
        BPET_IDLE = 4'b0001,
        BPET_SRC = 4'b0010,
        BPET_DST = 4'b0100,
        BPET_WR = 4'b1000
    } bpet_state_e;

endpackage : bpet_pkg

// ==== design/bpet_pixel_unit.sv ====
// Pixel combine: comparators, expansion, raster operation, transparency
`timescale 1ns/1ps
module bpet_pixel_unit
    import bpet_pkg::*;
(
    input wire bpet_pkg::bpet_cfg_s cfg,
    input wire bpet_pkg::bpet_colors_s col,
    input wire logic [7:0] src_pix,
    input wire logic [7:0] dst_pix,
    output logic [7:0] result,
    output logic write_en
);

    // Masked compare; planar pixels only use the four map bits
    function automatic logic color_match(input logic [7:0] pix,
        input logic [7:0] c, input logic [7:0] m, input logic planar);
        logic [7:0] diff;
        diff = (pix ^ c) & ~m;
        if (planar)
        begin
            diff[7:4] = 4'h0;
        end
        return diff == 8'h00;
    endfunction : color_match

    logic planar;
    logic mono;
    logic [7:0] fg;
    logic [7:0] bg;
    logic [7:0] s;
    logic [7:0] r;
    logic dst_hit;
    logic transparent;

    always_comb
    begin
        planar = !cfg.packed_mode;
        fg = planar ? {4'h0, col.fg[3:0]} : col.fg;
        bg = planar ? {4'h0, col.bg[3:0]} : col.bg;
        mono = color_match(src_pix, col.tcol, col.tmask, planar);
        if (cfg.fmt == BPET_FMT_FIXED)
        begin
            s = fg;
        end
        else if (cfg.extract)
        begin
            s = cfg.expand ? (mono ? fg : bg) : {8{mono}};
        end
        else
        begin
            s = src_pix;
        end
        // Raster operation acts on the expanded colours alike
        r = (~s & ~dst_pix & {8{col.rop[3]}}) |
            (~s & dst_pix & {8{col.rop[2]}}) |
            (s & ~dst_pix & {8{col.rop[1]}}) |
            (s & dst_pix & {8{col.rop[0]}});
        result = (r & col.pmask) | (dst_pix & ~col.pmask);
        if (planar)
        begin
            result[7:4] = 4'h0;
        end
        dst_hit = color_match(dst_pix, col.tcol, col.tmask, planar);
        transparent = cfg.tr_pol ? dst_hit : !dst_hit;
        write_en = 1'b1;
        // Comparator registers are busy while extracting
        if (cfg.tr_en && !(cfg.extract && cfg.fmt != BPET_FMT_FIXED))
        begin
            write_en = transparent;
        end
        if (cfg.mono_tr && cfg.extract && cfg.fmt != BPET_FMT_FIXED
            && !mono)
        begin
            write_en = 1'b0;
        end
    end

endmodule : bpet_pixel_unit

// ==== design/bpet_engine.sv ====
// Pixel-source stage of the block-transfer engine with APB registers
`timescale 1ns/1ps
module bpet_engine
    import bpet_pkg::*;
#(
    parameter int ADDR_W = 16
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic mem_req,
    output logic mem_we,
    output logic [ADDR_W-1:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [7:0] mem_rdata,
    output logic busy
);

    logic [15:0] ctrl0_q, ctrl0_d;
    logic [15:0] ctrl1_q, ctrl1_d;
    logic [15:0] src_q, src_d;
    logic [15:0] dst_q, dst_d;
    logic [15:0] dimx_q, dimx_d;
    logic [15:0] dimy_q, dimy_d;
    logic [3:0] rop_q, rop_d;
    logic [7:0] fg_q, fg_d;
    logic [7:0] bg_q, bg_d;
    logic [7:0] tcol_q, tcol_d;
    logic [7:0] tmask_q, tmask_d;
    logic [7:0] pmask_q, pmask_d;
    logic [31:0] host_q, host_d;
    logic [2:0] host_cnt_q, host_cnt_d;
    logic [31:0] prdata_q, prdata_d;
    logic slverr_q, slverr_d;

    bpet_state_e state_q, state_d;
    logic [15:0] x_q, x_d;
    logic [15:0] y_q, y_d;
    logic [15:0] lin_q, lin_d;
    logic [7:0] spix_q, spix_d;
    logic [7:0] dpix_q, dpix_d;

    bpet_cfg_s cfg;
    bpet_colors_s colors;
    logic [7:0] result;
    logic write_en;

    logic [7:0] idx;
    logic setup;
    logic access;
    logic host_wr;
    logic mapped;
    logic last_pix;
    logic [15:0] pat_addr;

    // Pattern pixel address: offset from the anchor, wrapped in both axes
    function automatic logic [15:0] pattern_addr(input logic [15:0] anchor,
        input logic [15:0] x, input logic [15:0] y);
        logic [2:0] col;
        logic [2:0] row;
        col = anchor[2:0] + x[2:0];
        row = anchor[5:3] + y[2:0];
        return (anchor & BPET_PAT_ALIGN) | {10'h000, row, col};
    endfunction : pattern_addr

    assign idx = paddr[9:2];
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign host_wr = pwrite && idx == BPET_IDX_HOST;
    // Host writes stall until the previous word is used up
    assign pready = !(host_wr && host_cnt_q != 3'h0);
    assign pslverr = slverr_q && access;
    assign prdata = prdata_q;
    assign busy = state_q != BPET_IDLE;

    assign cfg.fmt = ctrl0_q[BPET_C0_FMT_LSB +: 2];
    assign cfg.packed_mode = ctrl0_q[BPET_C0_PACKED];
    assign cfg.extract = ctrl0_q[BPET_C0_EXTRACT];
    assign cfg.pattern = ctrl0_q[BPET_C0_PATTERN];
    assign cfg.expand = ctrl0_q[BPET_C0_EXPAND];
    assign cfg.mono_tr = ctrl1_q[BPET_C1_MONO_TR];
    assign cfg.tr_en = ctrl1_q[BPET_C1_TR_EN];
    assign cfg.tr_pol = ctrl1_q[BPET_C1_TR_POL];
    assign colors = '{fg: fg_q, bg: bg_q, tcol: tcol_q, tmask: tmask_q,
                      pmask: pmask_q, rop: rop_q};

    assign last_pix = (x_q + 16'h0001 >= dimx_q)
                      && (y_q + 16'h0001 >= dimy_q);
    assign pat_addr = pattern_addr(src_q, x_q, y_q);

    bpet_pixel_unit u_pixel (
        .cfg(cfg),
        .col(colors),
        .src_pix(spix_q),
        .dst_pix(dpix_q),
        .result(result),
        .write_en(write_en)
    );

    assign mapped = paddr[11:10] == 2'h0 && idx inside {BPET_IDX_CTRL0,
        BPET_IDX_CTRL1, BPET_IDX_SRC, BPET_IDX_DIMX, BPET_IDX_DIMY,
        [BPET_IDX_ROP:BPET_IDX_DST]};

    always_comb
    begin
        ctrl0_d = ctrl0_q;
        ctrl1_d = ctrl1_q;
        src_d = src_q;
        dst_d = dst_q;
        dimx_d = dimx_q;
        dimy_d = dimy_q;
        rop_d = rop_q;
        fg_d = fg_q;
        bg_d = bg_q;
        tcol_d = tcol_q;
        tmask_d = tmask_q;
        pmask_d = pmask_q;
        host_d = host_q;
        host_cnt_d = host_cnt_q;
        prdata_d = prdata_q;
        slverr_d = slverr_q;
        if (state_q == BPET_SRC && cfg.fmt == BPET_FMT_HOST
            && host_cnt_q != 3'h0)
        begin
            // Bytes of the word are used low byte first
            host_d = {8'h00, host_q[31:8]};
            host_cnt_d = host_cnt_q - 3'h1;
        end
        if (state_q == BPET_WR && last_pix)
        begin
            ctrl0_d[BPET_C0_START] = 1'b0;
        end
        if (setup)
        begin
            slverr_d = !mapped;
            prdata_d = 32'h0000_0000;
            unique case (idx)
                BPET_IDX_CTRL0: prdata_d[15:0] = ctrl0_q;
                BPET_IDX_CTRL1: prdata_d[15:0] = ctrl1_q;
                BPET_IDX_SRC: prdata_d[15:0] = src_q;
                BPET_IDX_DST: prdata_d[15:0] = dst_q;
                BPET_IDX_DIMX: prdata_d[15:0] = dimx_q;
                BPET_IDX_DIMY: prdata_d[15:0] = dimy_q;
                BPET_IDX_ROP: prdata_d[11:8] = rop_q;
                BPET_IDX_FG: prdata_d[7:0] = fg_q;
                BPET_IDX_BG: prdata_d[7:0] = bg_q;
                BPET_IDX_TCOL: prdata_d[7:0] = tcol_q;
                BPET_IDX_TMASK: prdata_d[7:0] = tmask_q;
                BPET_IDX_PMASK: prdata_d[7:0] = pmask_q;
                BPET_IDX_STAT: prdata_d[15:0] = {12'h000,
                    host_cnt_q == 3'h0, busy, state_q[1], state_q[2]};
                default: ;
            endcase
        end
        // Setup registers are locked while a transfer runs
        if (access && pready && pwrite && mapped && !busy)
        begin
            unique case (idx)
                BPET_IDX_CTRL0: ctrl0_d = pwdata[15:0];
                BPET_IDX_CTRL1: ctrl1_d = pwdata[15:0];
                BPET_IDX_SRC: src_d = pwdata[15:0];
                BPET_IDX_DST: dst_d = pwdata[15:0];
                BPET_IDX_DIMX: dimx_d = pwdata[15:0];
                BPET_IDX_DIMY: dimy_d = pwdata[15:0];
                BPET_IDX_ROP: rop_d = pwdata[11:8];
                BPET_IDX_FG: fg_d = pwdata[7:0];
                BPET_IDX_BG: bg_d = pwdata[7:0];
                BPET_IDX_TCOL: tcol_d = pwdata[7:0];
                BPET_IDX_TMASK: tmask_d = pwdata[7:0];
                BPET_IDX_PMASK: pmask_d = pwdata[7:0];
                default: ;
            endcase
        end
        if (access && pready && host_wr)
        begin
            host_d = pwdata;
            host_cnt_d = BPET_HOST_PIX;
        end
    end

    // Pixel sequencer: fetch source, fetch destination, write back
    always_comb
    begin
        state_d = state_q;
        x_d = x_q;
        y_d = y_q;
        lin_d = lin_q;
        spix_d = spix_q;
        dpix_d = dpix_q;
        mem_req = 1'b0;
        mem_we = 1'b0;
        mem_addr = '0;
        unique case (state_q)
            BPET_IDLE:
            begin
                x_d = 16'h0000;
                y_d = 16'h0000;
                lin_d = 16'h0000;
                if (ctrl0_q[BPET_C0_START] && dimx_q != 16'h0000
                    && dimy_q != 16'h0000)
                begin
                    // No source fetch for a fixed colour fill
                    state_d = cfg.fmt == BPET_FMT_FIXED ? BPET_DST
                                                        : BPET_SRC;
                end
            end
            BPET_SRC:
            begin
                if (cfg.fmt == BPET_FMT_HOST)
                begin
                    if (host_cnt_q != 3'h0)
                    begin
                        spix_d = host_q[7:0];
                        state_d = BPET_DST;
                    end
                end
                else
                begin
                    mem_req = 1'b1;
                    mem_addr = ADDR_W'(cfg.pattern ? pat_addr
                                                   : src_q + lin_q);
                    if (mem_ack)
                    begin
                        spix_d = mem_rdata;
                        state_d = BPET_DST;
                    end
                end
            end
            BPET_DST:
            begin
                mem_req = 1'b1;
                mem_addr = ADDR_W'(dst_q + lin_q);
                if (mem_ack)
                begin
                    dpix_d = mem_rdata;
                    state_d = BPET_WR;
                end
            end
            BPET_WR:
            begin
                mem_req = write_en;
                mem_we = write_en;
                mem_addr = ADDR_W'(dst_q + lin_q);
                // Opaque or masked pixels skip the write cycle
                if (mem_ack || !write_en)
                begin
                    lin_d = lin_q + 16'h0001;
                    if (x_q + 16'h0001 >= dimx_q)
                    begin
                        x_d = 16'h0000;
                        y_d = y_q + 16'h0001;
                    end
                    else
                    begin
                        x_d = x_q + 16'h0001;
                    end
                    if (last_pix)
                    begin
                        state_d = BPET_IDLE;
                    end
                    else
                    begin
                        state_d = cfg.fmt == BPET_FMT_FIXED ? BPET_DST
                                                            : BPET_SRC;
                    end
                end
            end
            default: state_d = BPET_IDLE;
        endcase
    end

    assign mem_wdata = result;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl0_q <= BPET_RST_ZERO;
            ctrl1_q <= BPET_RST_ZERO;
            src_q <= BPET_RST_ZERO;
            dst_q <= BPET_RST_ZERO;
            dimx_q <= BPET_RST_ZERO;
            dimy_q <= BPET_RST_ZERO;
            rop_q <= BPET_RST_ROP;
            fg_q <= 8'h00;
            bg_q <= 8'h00;
            tcol_q <= 8'h00;
            tmask_q <= 8'h00;
            pmask_q <= BPET_RST_PMASK;
            host_q <= 32'h0000_0000;
            host_cnt_q <= 3'h0;
            prdata_q <= 32'h0000_0000;
            slverr_q <= 1'b0;
            state_q <= BPET_IDLE;
            x_q <= 16'h0000;
            y_q <= 16'h0000;
            lin_q <= 16'h0000;
            spix_q <= 8'h00;
            dpix_q <= 8'h00;
        end
        else
        begin
            ctrl0_q <= ctrl0_d;
            ctrl1_q <= ctrl1_d;
            src_q <= src_d;
            dst_q <= dst_d;
            dimx_q <= dimx_d;
            dimy_q <= dimy_d;
            rop_q <= rop_d;
            fg_q <= fg_d;
            bg_q <= bg_d;
            tcol_q <= tcol_d;
            tmask_q <= tmask_d;
            pmask_q <= pmask_d;
            host_q <= host_d;
            host_cnt_q <= host_cnt_d;
            prdata_q <= prdata_d;
            slverr_q <= slverr_d;
            state_q <= state_d;
            x_q <= x_d;
            y_q <= y_d;
            lin_q <= lin_d;
            spix_q <= spix_d;
            dpix_q <= dpix_d;
        end
    end

endmodule : bpet_engine

// ==== bench/bpet_engine_sva.sv ====
// Port checker for the pixel-source stage
`timescale 1ns/1ps
module bpet_engine_sva
    import bpet_pkg::*;
#(
    parameter int ADDR_W = 16
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [7:0] mem_rdata,
    input wire logic busy
);
    // Shadow of the registers; the last read before a write is the target
    logic [7:0] sh_q [16];
    logic [3:0] rop_q;
    logic [7:0] rd_q;
    logic [7:0] idx;
    logic wr_ok, wr_pix, fixed, pk, tren, pol, hit;
    assign idx = paddr[9:2];
    assign wr_ok = psel && penable && pready && pwrite && !busy;
    assign wr_pix = mem_req && mem_we && mem_ack;
    assign fixed = sh_q[0][1:0] == BPET_FMT_FIXED;
    assign pk = sh_q[0][BPET_C0_PACKED];
    assign tren = sh_q[1][BPET_C1_TR_EN];
    assign pol = sh_q[1][BPET_C1_TR_POL];
    assign hit = ((rd_q ^ sh_q[12]) & ~sh_q[13] & (pk ? 8'hff : 8'h0f)) == 0;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sh_q <= '{default: 8'h00};
            rop_q <= BPET_RST_ROP;
            rd_q <= 8'h00;
        end
        else
        begin
            if (wr_ok && idx < 8'h10)
                sh_q[idx[3:0]] <= pwdata[7:0];
            if (wr_ok && idx == BPET_IDX_ROP)
                rop_q <= pwdata[11:8];
            if (mem_req && mem_ack && !mem_we)
                rd_q <= mem_rdata;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    unmapped_err_a: assert property (psel && penable && paddr[11:10] == 0
        && !(idx inside {8'h00, 8'h01, 8'h02, 8'h06, 8'h07, [8'h09:8'h11]})
        |-> pslverr) else $error("unmapped index without slave error");
    reg_ready_a: assert property (psel && penable && idx != BPET_IDX_HOST
        |-> pready) else $error("register access stalled");
    req_hold_a: assert property (mem_req && !mem_ack |=> mem_req
        && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata))
        else $error("memory request changed before ack");
    idle_quiet_a: assert property (!busy |-> !mem_req)
        else $error("memory request while idle");
    fill_start_a: assert property ($rose(busy) && fixed |-> ##[0:4] mem_req)
        else $error("fill did not reach memory");
    fill_fg_a: assert property (wr_pix && fixed && pk && rop_q == 4'h3
        |-> mem_wdata == sh_q[10]) else $error("fill colour wrong");
    planar_low_a: assert property (wr_pix && !pk |-> mem_wdata[7:4] == 0)
        else $error("planar pixel high bits set");
    tr_hit_a: assert property (wr_pix && fixed && tren && pol |-> hit)
        else $error("opaque pixel overwritten");
    tr_miss_a: assert property (wr_pix && fixed && tren && !pol |-> !hit)
        else $error("matching pixel overwritten");
    fill_c: cover property (wr_pix && fixed && pk);
    stall_c: cover property (psel && penable && !pready);
    tr_c: cover property (wr_pix && fixed && tren && !pk);
endmodule : bpet_engine_sva

// ==== bench/bpet_mem_model.sv ====
// Display memory partner with keyed contents and variable answer delay
`timescale 1ns/1ps
module bpet_mem_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic mem_req,
    input wire logic [15:0] mem_addr,
    input wire logic slow,
    input wire logic [7:0] key,
    output logic mem_ack,
    output logic [7:0] mem_rdata
);
    logic [1:0] wait_q;
    logic [7:0] lf_q;
    logic [7:0] val;
    // Contents are the low address byte xor key, so no array is needed
    assign val = mem_addr[7:0] ^ key;
    // Outside the ack cycle the bus carries a changing pattern
    assign mem_rdata = mem_ack ? val : ~val ^ lf_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem_ack <= 1'b0;
            wait_q <= 2'h0;
            lf_q <= 8'h5b;
        end
        else
        begin
            mem_ack <= 1'b0;
            lf_q <= {lf_q[6:0], lf_q[7] ^ lf_q[5]};
            if (mem_req && !mem_ack)
            begin
                if (wait_q == 2'h0)
                begin
                    mem_ack <= 1'b1;
                    wait_q <= slow ? lf_q[1:0] : 2'h0;
                end
                else
                    wait_q <= wait_q - 2'h1;
            end
        end
    end
endmodule : bpet_mem_model

// ==== bench/blit_pattern_expand_transparency_bench.sv ====
// Self-checking bench for the pixel-source stage
`timescale 1ns/1ps
module blit_pattern_expand_transparency_bench;
    import bpet_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, slow = 1'b0, mem_ack, pready, pslverr;
    logic mem_req, mem_we, busy;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'h63df972d;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata, mem_rdata, key = 8'h00;
    logic [23:0] expq [$];
    int num_errors = 0, cmp_count = 0, srcrd = 0;
    always #12.5 pclk = ~pclk;
    bpet_engine i_bpet_engine (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .busy(busy));
    bpet_mem_model i_bpet_mem_model (.pclk(pclk), .presetn(presetn),
        .mem_req(mem_req), .mem_addr(mem_addr), .slow(slow), .key(key),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task automatic chk(input string nm, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] i,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, i, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, i, d, r, e);
    endtask : wr
    task automatic geo(input logic [15:0] s, d, input logic [7:0] x, y);
        wr(BPET_IDX_SRC, s);
        wr(BPET_IDX_DST, d);
        wr(BPET_IDX_DIMX, x);
        wr(BPET_IDX_DIMY, y);
        srcrd = 0;
    endtask : geo
    task automatic finish(input string nm);
        repeat (2) @(posedge pclk);
        while (busy !== 1'b0)
            @(posedge pclk);
        chk({nm, " leftover"}, 32'(expq.size()), 0);
        expq.delete();
        $display("test %s done", nm);
    endtask : finish
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    // Scoreboard: every acknowledged write takes the oldest note
    always @(posedge pclk)
        if (mem_req === 1'b1 && mem_ack === 1'b1)
        begin
            if (mem_we !== 1'b1)
                srcrd += int'(mem_addr[15:12] == 4'h4);
            else if (expq.size() == 0)
                chk("stray write", {mem_addr, mem_wdata}, '1);
            else
                chk("pixel", {mem_addr, mem_wdata}, expq.pop_front());
        end
    initial
    begin
        #2000000;
        num_errors++;
        tally_and_finish();
    end
    initial
    begin
        logic [31:0] r, w0, w1;
        logic e, hit;
        logic [7:0] fg, bg, t, m, d, c, kk;
        logic [15:0] a;
        logic [7:0] ri [11] = '{8'h00, 8'h01, 8'h02, 8'h06, 8'h07, 8'h09,
            8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 11; k++)
        begin
            apb(1'b0, ri[k], 0, r, e);
            chk("reset value", r, k == 5 ? 32'h300 : k == 10 ? 32'hff : 0);
        end
        wr(8'h03, '1);
        apb(1'b0, 8'h03, 0, r, e);
        chk("unmapped err", e, 1);
        chk("unmapped data", r, 0);
        wr(BPET_IDX_TMASK, 32'ha5);
        apb(1'b0, BPET_IDX_TMASK, 0, r, e);
        chk("mask rw", r, 32'ha5);
        $display("test registers done");
        for (int p = 0; p < 2; p++)
        begin
            fg = 8'(xs());
            wr(BPET_IDX_FG, fg);
            geo(16'h4000, 16'h0200, 5, 2);
            for (int n = 0; n < 10; n++)
                expq.push_back({16'h0200 + 16'(n), p ? fg : fg & 8'h0f});
            wr(BPET_IDX_CTRL0, {3'h1, 2'h0, p[0], BPET_FMT_FIXED});
            finish("fill");
            chk("fill source reads", srcrd, 0);
        end
        slow <= 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            kk = 8'(xs());
            key <= kk;
            w0 = xs();
            t = {~kk[7:6], w0[5:0]};
            fg = w0[15:8];
            wr(BPET_IDX_FG, fg);
            wr(BPET_IDX_TCOL, t);
            wr(BPET_IDX_TMASK, 8'h33);
            wr(BPET_IDX_CTRL1, {k[1], 2'b10});
            geo(16'h4000, 16'h0200, 16, 1);
            for (int n = 0; n < 16; n++)
            begin
                d = 8'(n) ^ kk;
                hit = ((d ^ t) & 8'hcc & (k[0] ? 8'hff : 8'h0f)) == 0;
                if (hit == k[1])
                    expq.push_back({16'h0200 + 16'(n), k[0] ? fg : fg & 8'h0f});
            end
            wr(BPET_IDX_CTRL0, {3'h1, 2'h0, k[0], BPET_FMT_FIXED});
            finish("transparency");
        end
        wr(BPET_IDX_ROP, 32'h600);
        for (int k = 0; k < 4; k++)
        begin
            kk = 8'(xs());
            key <= kk;
            w0 = xs();
            fg = w0[7:0];
            bg = w0[15:8];
            m = ~(8'h01 << w0[18:16]);
            wr(BPET_IDX_FG, fg);
            wr(BPET_IDX_BG, bg);
            wr(BPET_IDX_TCOL, 8'hff);
            wr(BPET_IDX_TMASK, m);
            wr(BPET_IDX_CTRL1, {2'b11, k[1]});
            geo(16'h4000, 16'h0310, 8, 1);
            for (int n = 0; n < 8; n++)
            begin
                hit = (((8'(n) ^ kk) ^ 8'hff) & ~m) == 0;
                c = k[0] ? (hit ? fg : bg) : {8{hit}};
                if (hit || !k[1])
                    expq.push_back({16'h0310 + 16'(n), c ^ (8'h10 + 8'(n)) ^ kk});
            end
            wr(BPET_IDX_CTRL0, k[0] ? 8'h6c : 8'h2c);
            finish("extract");
        end
        wr(BPET_IDX_ROP, 32'h300);
        wr(BPET_IDX_CTRL1, 0);
        for (int p = 0; p < 2; p++)
        begin
            kk = 8'(xs());
            key <= kk;
            geo(16'h4035, 16'h0400, 4, 3);
            for (int y = 0; y < 3; y++)
                for (int x = 0; x < 4; x++)
                begin
                    a = {10'h100, 3'(6 + y), 3'(5 + x)};
                    d = a[7:0] ^ kk;
                    expq.push_back({16'h0400 + 16'(y * 4 + x), p ? d : d & 8'h0f});
                end
            wr(BPET_IDX_CTRL0, p ? 8'h34 : 8'h30);
            finish("pattern");
            chk("pattern reads", srcrd, 12);
        end
        key <= 8'h3c;
        w0 = xs();
        w1 = xs();
        geo(16'h4000, 16'h0500, 8, 1);
        for (int n = 0; n < 8; n++)
            expq.push_back({16'h0500 + 16'(n), n < 4 ? w0[n*8 +: 8] : w1[n*8-32 +: 8]});
        wr(BPET_IDX_CTRL0, 8'h26);
        wr(BPET_IDX_HOST, w0);
        wr(BPET_IDX_HOST, w1);
        wr(BPET_IDX_FG, ~fg);
        finish("host port");
        apb(1'b0, BPET_IDX_FG, 0, r, e);
        chk("busy write ignored", r, {24'h0, fg});
        tally_and_finish();
    end
endmodule : blit_pattern_expand_transparency_bench
bind bpet_engine bpet_engine_sva #(.ADDR_W(ADDR_W)) i_bpet_engine_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .busy(busy));
